/* rtl/i2c_mode_pkg.sv */
// Constants, field layouts and state encodings of the I2C mode-control block.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package i2c_mode_pkg;

  localparam int ADDR_W = 8;

  localparam logic [7:0] OFS_MODE     = 8'h00;
  localparam logic [7:0] OFS_OWN      = 8'h04;
  localparam logic [7:0] OFS_TARGET   = 8'h08;
  localparam logic [7:0] OFS_COUNT    = 8'h0C;
  localparam logic [7:0] OFS_TX       = 8'h10;
  localparam logic [7:0] OFS_RX       = 8'h14;
  localparam logic [7:0] OFS_STATUS   = 8'h18;
  localparam logic [7:0] OFS_PRESCALE = 8'h1C;

  // Mode register, bit 9 down to bit 0.
  typedef struct packed {
    logic free_format_enable;
    logic address_expansion;
    logic repeat_transfer;
    logic loopback_enable;
    logic module_reset_n;
    logic start_byte_mode;
    logic start_condition_request;
    logic stop_condition_request;
    logic master_role;
    logic transmit_role;
  } mode_s;

  // Status register, bit 4 down to bit 0.
  typedef struct packed {
    logic overrun;
    logic nack;
    logic tx_ready;
    logic rx_ready;
    logic busy;
  } status_s;

  localparam logic [9:0]  MODE_RST     = 10'h000;
  localparam logic [9:0]  OWN_RST      = 10'h000;
  localparam logic [9:0]  TARGET_RST   = 10'h000;
  localparam logic [15:0] COUNT_RST    = 16'h0001;
  localparam logic [7:0]  PSC_MIN      = 8'h03;
  localparam logic [7:0]  START_BYTE   = 8'h01;
  localparam logic [4:0]  TEN_BIT_TAG  = 5'h1E;
  localparam logic [3:0]  ACK_SLOT     = 4'h8;
  localparam logic [3:0]  LAST_BIT     = 4'h7;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_START  = 6'h02,
    ST_LOAD   = 6'h04,
    ST_BITS   = 6'h08,
    ST_RSTART = 6'h10,
    ST_STOP   = 6'h20
  } eng_e;

  typedef enum logic [3:0] {
    K_SBYTE   = 4'h1,
    K_ADDR_HI = 4'h2,
    K_ADDR_LO = 4'h4,
    K_DATA    = 4'h8
  } kind_e;

endpackage

/* rtl/i2c_mode_control.sv */
// I2C master mode control: loopback, module enable, START byte preamble,
// addressed or free data format and repeat mode, behind AXI4-Lite.
// Assumes open-drain SCL/SDA resolved outside; pin inputs synchronous.
// Operation
// - Loopback acts only while master-transmitter; otherwise ignored.
// - Loopback: transmitted word lands in receive register after 8 slots.
// - Loopback uses the same slot clock for sending and receiving.
// - Loopback sends own address instead of target address.
// - Module reset bit low holds block disabled, status to defaults.
// - Disabling mid-transfer releases both lines; bus may hang.
// - As slave, START byte mode is ignored entirely.
// - START byte mode turns a start request into a longer preamble.
// - Preamble: START, byte 0000_0001, dummy ack clock, repeated START.
// - After preamble the target address is sent, or the data at once in free format.
// - Without free format, 7-bit or 10-bit addressing per expansion bit.
// - Repeat mode ignores data count until stop request is set.
`timescale 1ns/1ns
module i2c_mode_control #(
  parameter logic [7:0] PRESCALE_DEFAULT = 8'h04
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  s_awaddr_i,
  input  wire logic        s_awvalid_i,
  output logic             s_awready_o,
  input  wire logic [31:0] s_wdata_i,
  input  wire logic [3:0]  s_wstrb_i,
  input  wire logic        s_wvalid_i,
  output logic             s_wready_o,
  output logic [1:0]       s_bresp_o,
  output logic             s_bvalid_o,
  input  wire logic        s_bready_i,
  input  wire logic [7:0]  s_araddr_i,
  input  wire logic        s_arvalid_i,
  output logic             s_arready_o,
  output logic [31:0]      s_rdata_o,
  output logic [1:0]       s_rresp_o,
  output logic             s_rvalid_o,
  input  wire logic        s_rready_i,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o
);

  if (PRESCALE_DEFAULT < i2c_mode_pkg::PSC_MIN) begin : g_chk
    $error("PRESCALE_DEFAULT must be at least 3");
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  i2c_mode_pkg::mode_s mode_r, mode_nxt;
  i2c_mode_pkg::eng_e  state_r, state_nxt;
  i2c_mode_pkg::kind_e kind_r, kind_nxt;
  i2c_mode_pkg::status_s st;
  logic [9:0]  own_r, own_nxt, target_r, target_nxt;
  logic [15:0] cnt_reg_r, cnt_reg_nxt, count_r, count_nxt;
  logic [7:0]  tx_r, tx_nxt, rx_r, rx_nxt, psc_r, psc_nxt;
  logic [7:0]  div_r, div_nxt, sh_r, sh_nxt, rxsh_r, rxsh_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic        tx_pend_r, tx_pend_nxt, rx_rdy_r, rx_rdy_nxt;
  logic        nack_r, nack_nxt, ovr_r, ovr_nxt;
  logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic        scl_low_r, scl_low_nxt, sda_low_r, sda_low_nxt;

  logic        has_aw, has_w, do_wr, wr_tx, rd_rx, tx_take, rx_set;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic [7:0]  hi_start;
  logic [9:0]  src_addr;
  logic        loop_act, sending, last_byte, slot_end, sample, rx_bit;
  logic        want_sda;

  assign s_awready_o = !aw_hold_r && !bvalid_r;
  assign s_wready_o  = !w_hold_r && !bvalid_r;
  assign s_bvalid_o  = bvalid_r;
  assign s_bresp_o   = bresp_r;
  assign s_arready_o = !rvalid_r;
  assign s_rvalid_o  = rvalid_r;
  assign s_rdata_o   = rdata_r;
  assign s_rresp_o   = rresp_r;
  assign scl_o       = 1'b0;
  assign sda_o       = 1'b0;
  assign scl_oe_n_o  = !scl_low_r;
  assign sda_oe_n_o  = !sda_low_r;

  always_comb begin
    st.overrun  = ovr_r;
    st.nack     = nack_r;
    st.tx_ready = !tx_pend_r;
    st.rx_ready = rx_rdy_r;
    st.busy     = (state_r != i2c_mode_pkg::ST_IDLE);
  end

  always_comb begin
    mode_nxt = mode_r;      own_nxt = own_r;     target_nxt = target_r;
    cnt_reg_nxt = cnt_reg_r; count_nxt = count_r; tx_nxt = tx_r;
    rx_nxt = rx_r;          psc_nxt = psc_r;     div_nxt = div_r;
    sh_nxt = sh_r;          rxsh_nxt = rxsh_r;   bit_nxt = bit_r;
    state_nxt = state_r;    kind_nxt = kind_r;   nack_nxt = nack_r;
    ovr_nxt = ovr_r;        rx_set = 1'b0;       tx_take = 1'b0;
    aw_hold_nxt = aw_hold_r; w_hold_nxt = w_hold_r;
    awaddr_nxt = awaddr_r;  wdata_nxt = wdata_r; wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;  bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;  rdata_nxt = rdata_r; rresp_nxt = rresp_r;
    wr_tx = 1'b0;           rd_rx = 1'b0;

    // Write channel: address and data are taken in either order.
    has_aw = aw_hold_r || (s_awvalid_i && s_awready_o);
    has_w  = w_hold_r || (s_wvalid_i && s_wready_o);
    wa = aw_hold_r ? awaddr_r : s_awaddr_i;
    wd = w_hold_r ? wdata_r : s_wdata_i;
    ws = w_hold_r ? wstrb_r : s_wstrb_i;
    do_wr = has_aw && has_w;
    if (bvalid_r && s_bready_i) begin
      bvalid_nxt = 1'b0;
    end
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = i2c_mode_pkg::RESP_OKAY;
      case (wa)
        i2c_mode_pkg::OFS_MODE:
          mode_nxt = 10'(merge({22'h00_0000, mode_r}, wd, ws));
        i2c_mode_pkg::OFS_OWN:
          own_nxt = 10'(merge({22'h00_0000, own_r}, wd, ws));
        i2c_mode_pkg::OFS_TARGET:
          target_nxt = 10'(merge({22'h00_0000, target_r}, wd, ws));
        i2c_mode_pkg::OFS_COUNT:
          cnt_reg_nxt = 16'(merge({16'h0000, cnt_reg_r}, wd, ws));
        i2c_mode_pkg::OFS_TX: begin
          tx_nxt = 8'(merge({24'h00_0000, tx_r}, wd, ws));
          wr_tx  = ws[0];
        end
        i2c_mode_pkg::OFS_STATUS: begin
          if (ws[0] && wd[3]) nack_nxt = 1'b0;
          if (ws[0] && wd[4]) ovr_nxt = 1'b0;
        end
        i2c_mode_pkg::OFS_PRESCALE: begin
          psc_nxt = 8'(merge({24'h00_0000, psc_r}, wd, ws));
          if (psc_nxt < i2c_mode_pkg::PSC_MIN) psc_nxt = i2c_mode_pkg::PSC_MIN;
        end
        i2c_mode_pkg::OFS_RX: ;
        default: bresp_nxt = i2c_mode_pkg::RESP_SLVERR;
      endcase
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_hold_nxt = 1'b1;
        awaddr_nxt  = s_awaddr_i;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_hold_nxt = 1'b1;
        wdata_nxt  = s_wdata_i;
        wstrb_nxt  = s_wstrb_i;
      end
    end

    // Read channel: one read at a time, answered the cycle after it is taken.
    if (rvalid_r && s_rready_i) begin
      rvalid_nxt = 1'b0;
    end
    if (s_arvalid_i && s_arready_o) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = i2c_mode_pkg::RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      case (s_araddr_i)
        i2c_mode_pkg::OFS_MODE:     rdata_nxt[9:0]  = mode_r;
        i2c_mode_pkg::OFS_OWN:      rdata_nxt[9:0]  = own_r;
        i2c_mode_pkg::OFS_TARGET:   rdata_nxt[9:0]  = target_r;
        i2c_mode_pkg::OFS_COUNT:    rdata_nxt[15:0] = cnt_reg_r;
        i2c_mode_pkg::OFS_TX:       rdata_nxt[7:0]  = tx_r;
        i2c_mode_pkg::OFS_RX: begin
          rdata_nxt[7:0] = rx_r;
          rd_rx          = 1'b1;
        end
        i2c_mode_pkg::OFS_STATUS:   rdata_nxt[4:0]  = st;
        i2c_mode_pkg::OFS_PRESCALE: rdata_nxt[7:0]  = psc_r;
        default: rresp_nxt = i2c_mode_pkg::RESP_SLVERR;
      endcase
    end

    // Serial engine: one bit per slot of psc_r + 1 clock cycles.
    loop_act  = mode_r.loopback_enable && mode_r.master_role
                && mode_r.transmit_role;
    src_addr  = loop_act ? own_r : target_r;
    sending   = (kind_r != i2c_mode_pkg::K_DATA) || mode_r.transmit_role;
    last_byte = !mode_r.repeat_transfer && (count_r <= 16'h0001);
    hi_start  = {1'b0, psc_r[7:1]} + 8'h01;
    slot_end  = (div_r == psc_r);
    sample    = (div_r == hi_start);
    rx_bit    = loop_act ? !sda_low_r : sda_i;
    if (state_r != i2c_mode_pkg::ST_IDLE && !(scl_i || scl_low_r)) begin
      div_nxt = div_r;
    end else begin
      div_nxt = slot_end ? 8'h00 : div_r + 8'h01;
    end

    scl_low_nxt = 1'b0;
    want_sda    = 1'b0;
    case (state_r)
      i2c_mode_pkg::ST_IDLE: begin
        div_nxt = 8'h00;
        if (mode_r.master_role && mode_r.start_condition_request) begin
          mode_nxt.start_condition_request = 1'b0;
          count_nxt = cnt_reg_r;
          kind_nxt  = i2c_mode_pkg::K_DATA;
          state_nxt = i2c_mode_pkg::ST_START;
        end
      end
      i2c_mode_pkg::ST_RSTART: begin
        // SCL is pulsed low so that SDA can rise before the repeated START.
        scl_low_nxt = (div_r < hi_start);
        if (slot_end) begin
          state_nxt = i2c_mode_pkg::ST_START;
        end
      end
      i2c_mode_pkg::ST_START: begin
        want_sda = (div_r >= hi_start);
        if (slot_end) begin
          state_nxt = i2c_mode_pkg::ST_LOAD;
          if (kind_r != i2c_mode_pkg::K_SBYTE
              && mode_r.start_byte_mode) begin
            kind_nxt = i2c_mode_pkg::K_SBYTE;
          end else if (mode_r.free_format_enable) begin
            kind_nxt = i2c_mode_pkg::K_DATA;
          end else begin
            kind_nxt = i2c_mode_pkg::K_ADDR_HI;
          end
        end
      end
      i2c_mode_pkg::ST_LOAD: begin
        scl_low_nxt = 1'b1;
        want_sda    = 1'b1;
        if (slot_end) begin
          state_nxt = i2c_mode_pkg::ST_BITS;
          bit_nxt   = 4'h0;
          case (kind_r)
            i2c_mode_pkg::K_SBYTE: sh_nxt = i2c_mode_pkg::START_BYTE;
            i2c_mode_pkg::K_ADDR_HI:
              sh_nxt = mode_r.address_expansion
                ? {i2c_mode_pkg::TEN_BIT_TAG, src_addr[9:8],
                   !mode_r.transmit_role}
                : {src_addr[6:0], !mode_r.transmit_role};
            i2c_mode_pkg::K_ADDR_LO: sh_nxt = src_addr[7:0];
            default: begin
              sh_nxt = tx_r;
              if (mode_r.transmit_role) begin
                tx_take = tx_pend_r;
                if (mode_r.stop_condition_request) begin
                  mode_nxt.stop_condition_request = 1'b0;
                  state_nxt = i2c_mode_pkg::ST_STOP;
                end else if (!tx_pend_r) begin
                  state_nxt = i2c_mode_pkg::ST_LOAD;
                end
              end
            end
          endcase
        end
      end
      i2c_mode_pkg::ST_BITS: begin
        scl_low_nxt = (div_r < hi_start);
        if (bit_r < i2c_mode_pkg::ACK_SLOT) begin
          want_sda = sending && !sh_r[7];
        end else begin
          want_sda = (kind_r == i2c_mode_pkg::K_DATA)
                     && !mode_r.transmit_role && !last_byte;
        end
        if (sample && bit_r < i2c_mode_pkg::ACK_SLOT) begin
          rxsh_nxt = {rxsh_r[6:0], rx_bit};
        end
        if (sample && bit_r == i2c_mode_pkg::ACK_SLOT && sending
            && kind_r != i2c_mode_pkg::K_SBYTE && !loop_act && sda_i) begin
          nack_nxt = 1'b1;
        end
        if (slot_end && bit_r < i2c_mode_pkg::ACK_SLOT) begin
          sh_nxt  = {sh_r[6:0], 1'b0};
          bit_nxt = bit_r + 4'h1;
          if (bit_r == i2c_mode_pkg::LAST_BIT
              && kind_r == i2c_mode_pkg::K_DATA
              && (!mode_r.transmit_role || loop_act)) begin
            rx_nxt = rxsh_r;
            rx_set = 1'b1;
          end
        end else if (slot_end) begin
          state_nxt = i2c_mode_pkg::ST_LOAD;
          if (kind_r == i2c_mode_pkg::K_SBYTE) begin
            state_nxt = i2c_mode_pkg::ST_RSTART;
          end else if (nack_nxt && sending) begin
            state_nxt = i2c_mode_pkg::ST_STOP;
          end else if (kind_r == i2c_mode_pkg::K_ADDR_HI
                       && mode_r.address_expansion) begin
            kind_nxt = i2c_mode_pkg::K_ADDR_LO;
          end else if (kind_r != i2c_mode_pkg::K_DATA) begin
            kind_nxt = i2c_mode_pkg::K_DATA;
          end else begin
            count_nxt = count_r - 16'h0001;
            if (mode_r.stop_condition_request || last_byte) begin
              mode_nxt.stop_condition_request = 1'b0;
              state_nxt = i2c_mode_pkg::ST_STOP;
            end
          end
        end
      end
      i2c_mode_pkg::ST_STOP: begin
        scl_low_nxt = (div_r < hi_start);
        want_sda    = 1'b1;
        if (slot_end) begin
          state_nxt = i2c_mode_pkg::ST_IDLE;
        end
      end
      default: state_nxt = i2c_mode_pkg::ST_IDLE;
    endcase
    // Outside IDLE and START, SDA only changes after SCL has settled low, except when a low module reset bit releases both on one edge.
    if (div_r == 8'h00 && state_r != i2c_mode_pkg::ST_IDLE
        && state_r != i2c_mode_pkg::ST_START) begin
      sda_low_nxt = sda_low_r;
    end else begin
      sda_low_nxt = want_sda;
    end

    // Sets win over the clears in the same cycle; a low module reset bit clears them all.
    tx_pend_nxt = wr_tx || (tx_pend_r && !tx_take);
    rx_rdy_nxt  = rx_set || (rx_rdy_r && !rd_rx);
    if (rx_set && rx_rdy_r && !rd_rx) begin
      ovr_nxt = 1'b1;
    end

    if (!mode_r.module_reset_n) begin
      state_nxt   = i2c_mode_pkg::ST_IDLE;
      div_nxt     = 8'h00;
      scl_low_nxt = 1'b0;
      sda_low_nxt = 1'b0;
      tx_pend_nxt = 1'b0;
      rx_rdy_nxt  = 1'b0;
      nack_nxt    = 1'b0;
      ovr_nxt     = 1'b0;
      mode_nxt.start_condition_request = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= i2c_mode_pkg::MODE_RST;   own_r <= i2c_mode_pkg::OWN_RST;
      target_r <= i2c_mode_pkg::TARGET_RST;
      cnt_reg_r <= i2c_mode_pkg::COUNT_RST;
      count_r <= i2c_mode_pkg::COUNT_RST;
      tx_r <= 8'h00;  rx_r <= 8'h00;  psc_r <= PRESCALE_DEFAULT;
      div_r <= 8'h00; sh_r <= 8'h00;  rxsh_r <= 8'h00;  bit_r <= 4'h0;
      state_r <= i2c_mode_pkg::ST_IDLE; kind_r <= i2c_mode_pkg::K_DATA;
      tx_pend_r <= 1'b0; rx_rdy_r <= 1'b0; nack_r <= 1'b0; ovr_r <= 1'b0;
      aw_hold_r <= 1'b0; w_hold_r <= 1'b0; awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000; wstrb_r <= 4'h0;
      bvalid_r <= 1'b0; bresp_r <= 2'h0; rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000; rresp_r <= 2'h0;
      scl_low_r <= 1'b0; sda_low_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;       own_r <= own_nxt;   target_r <= target_nxt;
      cnt_reg_r <= cnt_reg_nxt; count_r <= count_nxt;
      tx_r <= tx_nxt;  rx_r <= rx_nxt;  psc_r <= psc_nxt;
      div_r <= div_nxt; sh_r <= sh_nxt; rxsh_r <= rxsh_nxt; bit_r <= bit_nxt;
      state_r <= state_nxt; kind_r <= kind_nxt;
      tx_pend_r <= tx_pend_nxt; rx_rdy_r <= rx_rdy_nxt;
      nack_r <= nack_nxt; ovr_r <= ovr_nxt;
      aw_hold_r <= aw_hold_nxt; w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt; wdata_r <= wdata_nxt; wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt; bresp_r <= bresp_nxt; rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt; rresp_r <= rresp_nxt;
      scl_low_r <= scl_low_nxt; sda_low_r <= sda_low_nxt;
    end
  end

endmodule // i2c_mode_control

/* bench/i2c_bus_partner.sv */
// Behavioural I2C slave that acknowledges every byte and logs each one.
// Assumes wired-AND SCL and SDA lines with pull-ups resolved by the bench.
`timescale 1ns/1ns
module i2c_bus_partner (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_pull_o
);
  logic [7:0] log_q[$];
  logic [7:0] shift_r;
  int         n_bits;
  int         n_starts;

  initial begin
    sda_pull_o = 1'b0;
    shift_r = 8'h00;
    n_bits = 0;
    n_starts = 0;
  end

  // A falling SDA while SCL is high starts or restarts a frame.
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      n_bits = 0;
      n_starts++;
    end
  end

  always @(posedge scl_i) begin
    if (n_bits < 8) shift_r = {shift_r[6:0], sda_i};
    n_bits++;
  end

  // The ack is driven from the falling SCL after the eighth bit.
  always @(negedge scl_i) begin
    if (n_bits == 8) sda_pull_o <= 1'b1;
    if (n_bits == 9) begin
      sda_pull_o <= 1'b0;
      n_bits = 0;
      log_q.push_back(shift_r);
    end
  end
endmodule // i2c_bus_partner

/* bench/i2c_mode_control_assertions.sv */
// Checker of register bus handshakes and line release of the I2C block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module i2c_mode_checker #(
  parameter logic [7:0] PRESCALE_DEFAULT = 8'h04
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  s_awaddr_i,
  input wire logic        s_awvalid_i,
  input wire logic        s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0]  s_wstrb_i,
  input wire logic        s_wvalid_i,
  input wire logic        s_wready_o,
  input wire logic [1:0]  s_bresp_o,
  input wire logic        s_bvalid_o,
  input wire logic        s_bready_i,
  input wire logic        s_arvalid_i,
  input wire logic        s_arready_o,
  input wire logic [31:0] s_rdata_o,
  input wire logic        s_rvalid_o,
  input wire logic        s_rready_i,
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe_n_o,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic aw_w;
  assign aw_w = s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o;

  a_write_answer: assert property (aw_w |=> s_bvalid_o)
    else $error("write response missing");
  a_bresp_hold: assert property (s_bvalid_o && !s_bready_i
    |=> s_bvalid_o && $stable(s_bresp_o)) else $error("bresp dropped");
  a_read_answer: assert property (s_arvalid_i && s_arready_o |=> s_rvalid_o)
    else $error("read response missing");
  a_rdata_hold: assert property (s_rvalid_o && !s_rready_i
    |=> s_rvalid_o && $stable(s_rdata_o)) else $error("rdata dropped");
  a_resp_refuse: assert property (s_bvalid_o |-> !s_awready_o && !s_wready_o)
    else $error("write taken while response pending");
  a_unmapped_err: assert property (aw_w && s_awaddr_i > 8'h1C
    |=> s_bresp_o == i2c_mode_pkg::RESP_SLVERR) else $error("no SLVERR");
  a_open_drain: assert property (!scl_o && !sda_o)
    else $error("line value not low");
  a_reset_release: assert property ($fell(rst_i)
    |-> scl_oe_n_o && sda_oe_n_o) else $error("lines held after reset");
  a_disable_release: assert property (aw_w && s_awaddr_i == 8'h00
    && s_wstrb_i[0] && !s_wdata_i[5] |-> ##[1:3] scl_oe_n_o && sda_oe_n_o)
    else $error("lines held while disabled");

  c_start_seen: cover property (scl_i && $fell(sda_i));
  c_slverr: cover property (s_bvalid_o && s_bresp_o == 2'h2);
  c_read_done: cover property (s_rvalid_o && s_rready_i);
endmodule // i2c_mode_checker

bind i2c_mode_control i2c_mode_checker #(
  .PRESCALE_DEFAULT(PRESCALE_DEFAULT)
) checker_i (.clk_i, .rst_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o,
  .s_wdata_i, .s_wstrb_i, .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o,
  .s_bready_i, .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rvalid_o,
  .s_rready_i, .scl_i, .scl_o, .scl_oe_n_o, .sda_i, .sda_o, .sda_oe_n_o);

/* bench/tb_i2c_mode_control.sv */
// Self-checking bench of the I2C mode-control block and an acking slave.
// Assumes prescale left at its default so each slot takes five cycles.
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_i2c_mode_control;
  logic        clk_i, rst_i, s_awvalid_i, s_wvalid_i, s_bready_i;
  logic        s_arvalid_i, s_rready_i, s_awready_o, s_wready_o, s_bvalid_o;
  logic        s_arready_o, s_rvalid_o, scl_o, scl_oe_n_o, sda_o, sda_oe_n_o;
  logic        sda_pull;
  logic [7:0]  s_awaddr_i, s_araddr_i;
  logic [31:0] s_wdata_i, s_rdata_o;
  logic [3:0]  s_wstrb_i;
  logic [1:0]  s_bresp_o, s_rresp_o, resp;
  wire         scl = scl_oe_n_o;
  wire         sda = sda_oe_n_o & ~sda_pull;
  int          n_errors, n_compared, cycles;

  i2c_mode_control #(.PRESCALE_DEFAULT(8'h04)) i2c_mode_control_i (
    .clk_i, .rst_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i,
    .s_wstrb_i, .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o,
    .s_bready_i, .s_araddr_i, .s_arvalid_i, .s_arready_o, .s_rdata_o,
    .s_rresp_o, .s_rvalid_o, .s_rready_i, .scl_i(scl), .scl_o, .scl_oe_n_o,
    .sda_i(sda), .sda_o, .sda_oe_n_o);
  i2c_bus_partner partner_i (.scl_i(scl), .sda_i(sda), .sda_pull_o(sda_pull));

  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    s_awaddr_i <= a;
    s_wdata_i <= d;
    s_awvalid_i <= 1'b1;
    s_wvalid_i <= 1'b1;
    s_bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_awready_o && s_awvalid_i) s_awvalid_i <= 1'b0;
      if (s_wready_o && s_wvalid_i) s_wvalid_i <= 1'b0;
    end while (s_bvalid_o !== 1'b1);
    resp = s_bresp_o;
    s_bready_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    s_araddr_i <= a;
    s_arvalid_i <= 1'b1;
    s_rready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_arready_o && s_arvalid_i) s_arvalid_i <= 1'b0;
    end while (s_rvalid_o !== 1'b1);
    d = s_rdata_o;
    resp = s_rresp_o;
    s_rready_i <= 1'b0;
  endtask

  task automatic poll(input int b, input logic v);
    logic [31:0] d;
    for (int k = 0; k < 400; k++) begin
      rd(i2c_mode_pkg::OFS_STATUS, d);
      if (d[b] === v) break;
    end
    `CHK(d[b], v)
  endtask

  // Enables first, since a disabled block drops a transmit write, then
  // loads the byte and raises the start request with the full mode.
  task automatic xfer(input logic [9:0] mode, input logic [9:0] tgt);
    partner_i.log_q.delete();
    wr(i2c_mode_pkg::OFS_TARGET, {22'h0, tgt});
    wr(i2c_mode_pkg::OFS_MODE, {22'h0, mode & ~10'h008});
    wr(i2c_mode_pkg::OFS_TX, 32'h0000_00A5);
    wr(i2c_mode_pkg::OFS_MODE, {22'h0, mode});
  endtask

  task automatic wait_idle();
    repeat (20) @(posedge clk_i);
    poll(0, 1'b0);
  endtask

  task automatic chk_log(input logic [7:0] e[$]);
    `CHK(partner_i.log_q.size(), e.size())
    foreach (e[k]) `CHK(partner_i.log_q[k], e[k])
  endtask

  task automatic t_reset();
    logic [31:0] d;
    rd(i2c_mode_pkg::OFS_MODE, d);
    `CHK(d, 32'h0000_0000)
    rd(i2c_mode_pkg::OFS_COUNT, d);
    `CHK(d[15:0], i2c_mode_pkg::COUNT_RST)
    rd(i2c_mode_pkg::OFS_PRESCALE, d);
    `CHK(d[7:0], 8'h04)
    rd(i2c_mode_pkg::OFS_STATUS, d);
    `CHK(d[4:0], 5'h04)
    rd(8'h40, d);
    `CHK({resp, d}, {i2c_mode_pkg::RESP_SLVERR, 32'h0000_0000})
    wr(8'h40, 32'hFFFF_FFFF);
    `CHK(resp, i2c_mode_pkg::RESP_SLVERR)
  endtask

  task automatic t_plain();
    xfer(10'h02B, 10'h055);
    wait_idle();
    chk_log('{8'hAA, 8'hA5});
  endtask

  task automatic t_start_byte();
    int n;
    n = partner_i.n_starts;
    xfer(10'h03B, 10'h055);
    wait_idle();
    chk_log('{8'h01, 8'hAA, 8'hA5});
    `CHK(partner_i.n_starts - n, 2)
  endtask

  task automatic t_ten_bit();
    xfer(10'h12B, 10'h2A5);
    wait_idle();
    chk_log('{8'hF4, 8'hA5, 8'hA5});
    xfer(10'h22B, 10'h055);
    wait_idle();
    chk_log('{8'hA5});
  endtask

  task automatic t_loopback();
    logic [31:0] d;
    wr(i2c_mode_pkg::OFS_OWN, 32'h0000_003C);
    xfer(10'h06B, 10'h055);
    wait_idle();
    `CHK(partner_i.log_q[0], 8'h78)
    rd(i2c_mode_pkg::OFS_RX, d);
    `CHK(d[7:0], 8'hA5)
  endtask

  task automatic t_repeat();
    partner_i.log_q.delete();
    wr(i2c_mode_pkg::OFS_TX, 32'h0000_0011);
    wr(i2c_mode_pkg::OFS_MODE, 32'h0000_00A3);
    wr(i2c_mode_pkg::OFS_MODE, 32'h0000_00AB);
    poll(2, 1'b1);
    wr(i2c_mode_pkg::OFS_TX, 32'h0000_0022);
    poll(2, 1'b1);
    wr(i2c_mode_pkg::OFS_TX, 32'h0000_0033);
    poll(2, 1'b1);
    wr(i2c_mode_pkg::OFS_MODE, 32'h0000_00A7);
    wait_idle();
    chk_log('{8'hAA, 8'h11, 8'h22, 8'h33});
  endtask

  task automatic t_slave();
    xfer(10'h038, 10'h055);
    repeat (200) @(posedge clk_i);
    `CHK(partner_i.log_q.size(), 0)
  endtask

  task automatic t_disable();
    logic [31:0] d;
    xfer(10'h02B, 10'h055);
    repeat (30) @(posedge clk_i);
    wr(i2c_mode_pkg::OFS_MODE, 32'h0000_0000);
    repeat (3) @(posedge clk_i);
    `CHK({scl_oe_n_o, sda_oe_n_o}, 2'b11)
    rd(i2c_mode_pkg::OFS_STATUS, d);
    `CHK(d[4:0], 5'h04)
  endtask

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    {rst_i, s_awvalid_i, s_wvalid_i, s_bready_i} = 4'h8;
    {s_arvalid_i, s_rready_i, s_awaddr_i, s_araddr_i} = 18'h0_0000;
    s_wdata_i = 32'h0000_0000;
    s_wstrb_i = 4'hF;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_plain();
    t_start_byte();
    t_ten_bit();
    t_loopback();
    t_repeat();
    t_slave();
    t_disable();
    finish_test();
  end
endmodule // tb_i2c_mode_control
